// ---- hdl/limp_home_reset_control.sv ----
// mode, limp home and reset control behind an apb register slave
// Function
// - fail safe request high enters limp home
// - limp home routes inputs to channels 4,5
// - limp home holds channel, routing and mask registers at reset
// - fail safe request wakes device from stand-by
// - leaving limp home always goes to sleep
// - any reset: channels off except 4,5 in limp home, channel, routing and mask registers default, diagnosis kept in limp home
// - any reset sets transmission error flag
// - undervoltage reads return default frame with flag
// - undervoltage released only when all supplies good
// - soft reset bit resets channel, routing and mask registers and diagnosis
// - limp home keeps serial reads working
// - limp home ignores all serial writes
`timescale 1ns/1ns
`default_nettype none
`include "limp_home_params.svh"
module limp_home_reset_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fail_safe_request,
   input wire logic in1_pin,
   input wire logic in2_pin,
   input wire logic supply_bb_ok,
   input wire logic supply_dd_ok,
   input wire logic [7:0] diag_in,
   output logic [7:0] chan_out,
   output logic irq
);
   // three-stage synchronisers for the pins
   logic [2:0] fs_sync_r;
   logic [2:0] in1_sync_r;
   logic [2:0] in2_sync_r;
   logic [2:0] bb_sync_r;
   logic [2:0] dd_sync_r;
   logic fs_r;
   logic in1_r;
   logic in2_r;
   logic bb_ok_r;
   logic dd_ok_r;
   limp_home_pkg::mode_e mode_r;
   limp_home_pkg::mode_e mode_nxt;
   limp_home_pkg::status_s status;
   logic [7:0] chan_r;
   logic [3:0] incfg_r;
   logic [3:0] irq_stat_r;
   logic [3:0] irq_mask_r;
   logic [7:0] diag_r;
   logic soft_rst_r;
   logic uv;
   logic limp;
   logic any_rst;
   logic setup;
   logic access;
   logic wr_ok;
   logic [3:0] irq_set;
   logic limp_d_r;
   logic uv_d_r;
   logic [7:0] chan_nxt;
   logic [31:0] rd_val;
   logic rd_err;
   // decoded writes and diagnosis clear
   logic wr_ctrl;
   logic wr_chan;
   logic wr_incfg;
   logic wr_stat;
   logic wr_mask;
   logic diag_clr;

   // selection of one channel source from its two-bit field
   function automatic logic route(input logic [1:0] sel, input logic a,
                                  input logic b);
      case (sel)
         `SEL_IN1: route = a;
         `SEL_IN2: route = b;
         `SEL_ON: route = 1'b1;
         default: route = 1'b0;
      endcase
   endfunction : route

   // a level change counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fs_sync_r <= 3'h0;
         in1_sync_r <= 3'h0;
         in2_sync_r <= 3'h0;
         bb_sync_r <= 3'h0;
         dd_sync_r <= 3'h0;
      end else begin
         fs_sync_r <= {fs_sync_r[1:0], fail_safe_request};
         in1_sync_r <= {in1_sync_r[1:0], in1_pin};
         in2_sync_r <= {in2_sync_r[1:0], in2_pin};
         bb_sync_r <= {bb_sync_r[1:0], supply_bb_ok};
         dd_sync_r <= {dd_sync_r[1:0], supply_dd_ok};
      end
   end

   // filtered levels; supplies start as failed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fs_r <= 1'b0;
         in1_r <= 1'b0;
         in2_r <= 1'b0;
         bb_ok_r <= 1'b0;
         dd_ok_r <= 1'b0;
      end else begin
         if (fs_sync_r[1] == fs_sync_r[2]) fs_r <= fs_sync_r[2];
         if (in1_sync_r[1] == in1_sync_r[2]) in1_r <= in1_sync_r[2];
         if (in2_sync_r[1] == in2_sync_r[2]) in2_r <= in2_sync_r[2];
         if (bb_sync_r[1] == bb_sync_r[2]) bb_ok_r <= bb_sync_r[2];
         if (dd_sync_r[1] == dd_sync_r[2]) dd_ok_r <= dd_sync_r[2];
      end
   end

   // reset sources
   assign uv = !(bb_ok_r && dd_ok_r);
   assign limp = (mode_r == limp_home_pkg::MODE_LIMP);
   assign any_rst = uv || soft_rst_r || limp;
   assign diag_clr = uv || soft_rst_r;

   // apb phases; writes refused under limp home or undervoltage
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wr_ok = access && pwrite && !limp && !uv;

   // accepted writes per register
   assign wr_ctrl = wr_ok && (paddr == `ADDR_CTRL);
   assign wr_chan = wr_ok && (paddr == `ADDR_CHAN);
   assign wr_incfg = wr_ok && (paddr == `ADDR_INCFG);
   assign wr_stat = wr_ok && (paddr == `ADDR_IRQ_STAT);
   assign wr_mask = wr_ok && (paddr == `ADDR_IRQ_MASK);

   // mode sequencing
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         limp_home_pkg::MODE_SLEEP: begin
            if (fs_r) mode_nxt = limp_home_pkg::MODE_LIMP;
            else if (wr_ctrl && pwdata[`CTRL_WAKE])
               mode_nxt = limp_home_pkg::MODE_ACTIVE;
         end
         limp_home_pkg::MODE_ACTIVE: begin
            if (fs_r) mode_nxt = limp_home_pkg::MODE_LIMP;
            else if (wr_ctrl && pwdata[`CTRL_SLEEP])
               mode_nxt = limp_home_pkg::MODE_SLEEP;
         end
         limp_home_pkg::MODE_LIMP: begin
            if (!fs_r) mode_nxt = limp_home_pkg::MODE_SLEEP;
         end
         default: mode_nxt = limp_home_pkg::MODE_SLEEP;
      endcase
   end

   // mode register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) mode_r <= limp_home_pkg::MODE_SLEEP;
      else mode_r <= mode_nxt;
   end

   // soft reset is a one-cycle pulse from the command bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) soft_rst_r <= 1'b0;
      else soft_rst_r <= wr_ctrl &&
                         pwdata[`CTRL_SOFT_RST];
   end

   // channel enable register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) chan_r <= `CHAN_RST;
      else if (any_rst) chan_r <= `CHAN_RST;
      else if (wr_chan) chan_r <= pwdata[7:0];
   end

   // input routing for channels 4 and 5
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) incfg_r <= `INCFG_RST;
      else if (any_rst) incfg_r <= `INCFG_RST;
      else if (wr_incfg) incfg_r <= pwdata[3:0];
   end

   // interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq_mask_r <= `MASK_RST;
      else if (any_rst) irq_mask_r <= `MASK_RST;
      else if (wr_mask) irq_mask_r <= pwdata[3:0];
   end

   // diagnosis flags, sticky; kept through limp home for reads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) diag_r <= `DIAG_RST;
      else if (diag_clr) diag_r <= `DIAG_RST;
      else diag_r <= diag_r | diag_in;
   end

   // edge history for event flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         limp_d_r <= 1'b0;
         uv_d_r <= 1'b0;
      end else begin
         limp_d_r <= limp;
         uv_d_r <= uv;
      end
   end

   // events; the error flag is set while any reset holds
   always_comb begin
      irq_set = 4'h0;
      irq_set[`IRQ_TER] = any_rst;
      irq_set[`IRQ_LIMP_IN] = limp && !limp_d_r;
      irq_set[`IRQ_LIMP_OUT] = !limp && limp_d_r;
      irq_set[`IRQ_UV] = uv && !uv_d_r;
   end

   // sticky status, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq_stat_r <= `IRQ_STAT_RST;
      else if (wr_stat)
         irq_stat_r <= (irq_stat_r & ~pwdata[3:0]) | irq_set;
      else irq_stat_r <= irq_stat_r | irq_set;
   end

   // level interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq <= 1'b0;
      else irq <= |(irq_stat_r & irq_mask_r);
   end

   // channel drive per mode
   always_comb begin
      chan_nxt = 8'h00;
      if (limp) begin
         chan_nxt[4] = in1_r;
         chan_nxt[5] = in2_r;
      end else if (!any_rst && mode_r == limp_home_pkg::MODE_ACTIVE) begin
         chan_nxt = chan_r;
         chan_nxt[4] = route(incfg_r[1:0], in1_r, in2_r);
         chan_nxt[5] = route(incfg_r[3:2], in1_r, in2_r);
      end
   end

   // registered channel outputs, off on undervoltage or soft reset except channels 4,5 in limp home
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) chan_out <= 8'h00;
      else chan_out <= chan_nxt;
   end

   // status word
   always_comb begin
      status = '0;
      status.mode = mode_r;
      status.any_rst = any_rst;
      status.fail_safe = fs_r;
      status.uv = uv;
      status.soft_rst = soft_rst_r;
      status.transmission_error_flag = irq_stat_r[`IRQ_TER];
   end

   // read decode; reads stay open in limp home
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_err = 1'b0;
      case (paddr)
         `ADDR_CTRL: rd_val = 32'h0000_0000;
         `ADDR_CHAN: rd_val = {24'h000000, chan_r};
         `ADDR_INCFG: rd_val = {28'h0000000, incfg_r};
         `ADDR_STATUS: rd_val = status;
         `ADDR_IRQ_STAT: rd_val = {28'h0000000, irq_stat_r};
         `ADDR_IRQ_MASK: rd_val = {28'h0000000, irq_mask_r};
         `ADDR_DIAG: rd_val = {24'h000000, diag_r};
         default: rd_err = 1'b1;
      endcase
      if (uv) begin
         rd_val = `STD_DIAG_FRAME;
         rd_val[`TER_BIT] = 1'b1;
      end
   end

   // read data and error captured in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_val;
         pslverr <= rd_err;
      end
   end

   // one wait-free access phase
   assign pready = access;
endmodule : limp_home_reset_control
`default_nettype wire

// ---- include/limp_home_params.svh ----
// register offsets, field positions and reset values of the reset control
`ifndef LIMP_HOME_PARAMS_SVH
`define LIMP_HOME_PARAMS_SVH
`define ADDR_CTRL 12'h000
`define ADDR_CHAN 12'h004
`define ADDR_INCFG 12'h008
`define ADDR_STATUS 12'h00C
`define ADDR_IRQ_STAT 12'h010
`define ADDR_IRQ_MASK 12'h014
`define ADDR_DIAG 12'h018
`define CTRL_SOFT_RST 0
`define CTRL_SLEEP 1
`define CTRL_WAKE 2
`define IRQ_TER 0
`define IRQ_LIMP_IN 1
`define IRQ_LIMP_OUT 2
`define IRQ_UV 3
`define CHAN_RST 8'h00
`define INCFG_RST 4'h0
`define MASK_RST 4'h0
`define IRQ_STAT_RST 4'h1
`define DIAG_RST 8'h00
`define STD_DIAG_FRAME 32'h0000_0000
`define TER_BIT 31
`define SEL_OFF 2'h0
`define SEL_IN1 2'h1
`define SEL_IN2 2'h2
`define SEL_ON 2'h3
`endif

// ---- include/limp_home_pkg.sv ----
// types of the limp home reset control
package limp_home_pkg;
   typedef enum logic [1:0] {
      MODE_SLEEP = 2'b00,
      MODE_ACTIVE = 2'b01,
      MODE_LIMP = 2'b10
   } mode_e;
   // layout of the read-only status word
   typedef struct packed {
      logic [24:0] zero;
      logic transmission_error_flag;
      logic soft_rst;
      logic uv;
      logic fail_safe;
      logic any_rst;
      mode_e mode;
   } status_s;
endpackage : limp_home_pkg

// ---- tb/limp_home_host.sv ----
// far-side model: fail-safe request and supply monitors
`timescale 1ns/1ns
`default_nettype none
module limp_home_host (
   input wire logic pclk,
   input wire logic limp_req,
   input wire logic uv_bb,
   input wire logic uv_dd,
   output var logic fail_safe_request = 1'b0,
   output var logic supply_bb_ok = 1'b0,
   output var logic supply_dd_ok = 1'b0
);
   // pins change just after the clock edge, never between edges
   always @(posedge pclk) begin
      fail_safe_request <= limp_req;
      supply_bb_ok <= !uv_bb;
      supply_dd_ok <= !uv_dd;
   end
endmodule : limp_home_host
`default_nettype wire

// ---- tb/limp_home_reset_control_props.sv ----
// port checker of the limp home reset control
`timescale 1ns/1ns
`default_nettype none
`include "limp_home_params.svh"
module limp_home_reset_control_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic fail_safe_request,
   input wire logic in1_pin,
   input wire logic in2_pin,
   input wire logic supply_bb_ok,
   input wire logic [7:0] chan_out,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // held request, held undervoltage, read access
   sequence s_limp; fail_safe_request [*8]; endsequence
   sequence s_uv; (!supply_bb_ok) [*8]; endsequence
   sequence s_rd; psel && penable && !pwrite; endsequence
   AST_READY: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   AST_LIMP_PINS: assert property ((fail_safe_request
      && $stable({in1_pin, in2_pin})) [*8]
      |-> chan_out[5:4] == {in2_pin, in1_pin})
      else $error("limp channels not following pins");
   AST_LIMP_OTHERS: assert property (s_limp
      |-> chan_out[3:0] == 4'h0 && chan_out[7:6] == 2'h0)
      else $error("other channels on in limp home");
   AST_LIMP_IRQ: assert property (s_limp |-> !irq)
      else $error("irq with mask held at reset");
   AST_LIMP_STATUS: assert property (s_limp ##0 s_rd
      ##0 paddr == `ADDR_STATUS |-> prdata[1:0] == 2'h2 && prdata[3])
      else $error("status not limp home");
   AST_UV_OFF: assert property (s_uv |-> chan_out == 8'h00)
      else $error("channel on in undervoltage");
   AST_UV_READ: assert property (s_uv ##0 s_rd
      |-> prdata == 32'h8000_0000)
      else $error("undervoltage read not default frame");
   AST_SOFT_OFF: assert property (psel && penable && pwrite
      && paddr == `ADDR_CTRL && pwdata[0] && !fail_safe_request
      |-> ##[1:4] chan_out == 8'h00)
      else $error("soft reset left a channel on");
endmodule : limp_home_reset_control_props
bind limp_home_reset_control limp_home_reset_control_props u_props (.pclk,
   .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .fail_safe_request, .in1_pin, .in2_pin, .supply_bb_ok, .chan_out, .irq);
`default_nettype wire

// ---- tb/limp_home_reset_control_bench.sv ----
// self-checking bench of the limp home reset control
`timescale 1ns/1ns
`default_nettype none
`include "limp_home_params.svh"
module limp_home_reset_control_bench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h26;
   logic pready, pslverr, err, in1_pin = 0, in2_pin = 0, irq;
   logic fail_safe_request, supply_bb_ok, supply_dd_ok;
   logic limp_req = 0, uv_bb = 1, uv_dd = 1;
   logic [7:0] chan_out, chan_m;
   logic [7:0] diag_v, m_diag = 8'h00, diag_in = 8'h00;
   logic [3:0] cfg;
   logic [1:0] route_exp;
   logic lvl;
   int n_errors = 0, checks_done = 0, cyc = 0;
   limp_home_reset_control u_dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .fail_safe_request, .in1_pin, .in2_pin, .supply_bb_ok,
      .supply_dd_ok, .diag_in, .chan_out, .irq);
   limp_home_host u_host (.pclk, .limp_req, .uv_bb, .uv_dd,
      .fail_safe_request, .supply_bb_ok, .supply_dd_ok);
   // clock and hang guard
   initial forever #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         test_done();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // expected channel source for a two-bit routing field
   function automatic logic pick(input logic [1:0] s, input logic a,
      input logic c);
      case (s)
         2'h0: return 1'b0;
         2'h1: return a;
         2'h2: return c;
         default: return 1'b1;
      endcase
   endfunction : pick
   task automatic test_done();
      if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   // main sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      apb(0, `ADDR_STATUS, 0);
      chk(rd, 32'h8000_0000);
      uv_bb <= 0;
      uv_dd <= 0;
      repeat (8) @(posedge pclk);
      apb(1, `ADDR_CTRL, 4);
      chan_m = 8'(rnd()) & 8'hCF | 8'h01;
      apb(1, `ADDR_CHAN, {24'h0, chan_m});
      repeat (2) @(posedge pclk);
      chk(chan_out, chan_m);
      apb(1, `ADDR_IRQ_MASK, 1);
      repeat (2) @(posedge pclk);
      chk(irq, 1);
      apb(1, `ADDR_IRQ_STAT, 1);
      repeat (2) @(posedge pclk);
      chk(irq, 0);
      // register routing of channels 4 and 5, every code
      for (int k = 0; k < 4; k++) begin
         cfg = {2'(3 - k), 2'(k)};
         lvl = 1'(rnd());
         in1_pin <= lvl;
         in2_pin <= !lvl;
         apb(1, `ADDR_INCFG, {28'h0, cfg});
         repeat (6) @(posedge pclk);
         route_exp = {pick(cfg[3:2], lvl, !lvl), pick(cfg[1:0], lvl, !lvl)};
         chk(chan_out[5:4], route_exp);
      end
      // sticky diagnosis flag, then cleared by the soft reset
      diag_v = 8'(rnd()) | 8'h01;
      diag_in <= diag_v;
      @(posedge pclk);
      diag_in <= 8'h00;
      apb(0, `ADDR_DIAG, 0);
      chk(rd, {24'h0, diag_v});
      apb(1, `ADDR_CTRL, 1);
      repeat (4) @(posedge pclk);
      chk(chan_out, 0);
      apb(0, `ADDR_INCFG, 0);
      chk(rd, 0);
      apb(0, `ADDR_DIAG, 0);
      chk(rd, 0);
      apb(0, `ADDR_IRQ_STAT, 0);
      chk(rd[0], 1);
      apb(0, `ADDR_IRQ_MASK, 0);
      chk(rd, 0);
      apb(0, 12'h01C, 0);
      chk(err, 1);
      // limp home entered from active, then from sleep
      for (int i = 0; i < 2; i++) begin
         if (i == 0) apb(1, `ADDR_CTRL, 4);
         apb(1, `ADDR_CHAN, 32'hFF);
         apb(1, `ADDR_INCFG, 32'hF);
         diag_v = 8'(rnd()) | 8'h80;
         m_diag |= diag_v;
         diag_in <= diag_v;
         limp_req <= 1;
         {in2_pin, in1_pin} <= 2'(rnd());
         repeat (10) @(posedge pclk);
         chk(chan_out, {2'h0, in2_pin, in1_pin, 4'h0});
         apb(1, `ADDR_CHAN, 32'h0F);
         apb(0, `ADDR_STATUS, 0);
         chk(rd[1:0], 2);
         apb(0, `ADDR_CHAN, 0);
         chk(rd, 0);
         apb(0, `ADDR_INCFG, 0);
         chk(rd, 0);
         apb(0, `ADDR_DIAG, 0);
         chk(rd, {24'h0, m_diag});
         diag_in <= 8'h00;
         limp_req <= 0;
         repeat (8) @(posedge pclk);
         apb(0, `ADDR_STATUS, 0);
         chk(rd[1:0], 0);
         chk(chan_out, 0);
      end
      apb(0, `ADDR_IRQ_STAT, 0);
      chk(rd, 32'hF);
      // undervoltage in mid-run, released supply by supply
      apb(1, `ADDR_CTRL, 4);
      apb(1, `ADDR_CHAN, 32'h0F);
      uv_bb <= 1;
      uv_dd <= 1;
      repeat (8) @(posedge pclk);
      uv_dd <= 0;
      repeat (8) @(posedge pclk);
      apb(0, `ADDR_CHAN, 0);
      chk(rd, 32'h8000_0000);
      uv_bb <= 0;
      repeat (8) @(posedge pclk);
      apb(0, `ADDR_CHAN, 0);
      chk(rd, 0);
      apb(0, `ADDR_IRQ_STAT, 0);
      chk(rd[0], 1);
      apb(0, `ADDR_DIAG, 0);
      chk(rd, 0);
      apb(0, `ADDR_STATUS, 0);
      chk(rd[1:0], 1);
      apb(1, `ADDR_CTRL, 2);
      apb(0, `ADDR_STATUS, 0);
      chk(rd[1:0], 0);
      test_done();
   end
endmodule : limp_home_reset_control_bench
`default_nettype wire
